// ### core/dcfifo_consts.svh
`ifndef DCFIFO_CONSTS_SVH
`define DCFIFO_CONSTS_SVH

// Default storage geometry.
`define FIFO_DEPTH 8
`define FIFO_WIDTH 8

// Bit positions flipped by the error injection inputs.
`define SBIT_POS 0
`define DBIT_POS 1

// Reset values.
`define DOUT_RST 1'h0
`define EMPTY_RST 1'h1
`define PFULL_RST 1'h0

`endif

// ### core/dcfifo_pkg.sv
`include "dcfifo_consts.svh"

package dcfifo_pkg;

  // Three stage pin synchroniser with its settled value.
  typedef struct packed {
    logic [2:0] sh;
    logic flt;
  } pin_sync_type;

  // Shift one sample in; the settled value moves only when stages 2 and 3
  // agree, so stage 1 is never looked at by anything but stage 2.
  function automatic pin_sync_type sync_step(pin_sync_type cur,
                                             logic pin);
    pin_sync_type nx;
    nx.sh = {cur.sh[1:0], pin};
    nx.flt = (cur.sh[1] == cur.sh[2]) ? cur.sh[2] : cur.flt;
    return nx;
  endfunction

endpackage

// ### core/word_fifo.sv
`timescale 1ns/10ps

`include "dcfifo_consts.svh"

module word_fifo #(
  parameter int WIDTH = `FIFO_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic sys_clk, // System clock.
  input wire logic rstn, // Synchronous reset, active low.
  input wire logic clear, // Drops all stored words.
  input wire logic in_valid, // Word offered.
  output logic in_ready, // Room for a word.
  input wire logic [WIDTH-1:0] in_data, // Word to store.
  output logic out_valid, // Oldest word present.
  input wire logic out_ready, // Oldest word taken.
  output logic [WIDTH-1:0] out_data // Oldest word.
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("word_fifo depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } fifo_state_type;

  fifo_state_type q;
  fifo_state_type d;
  logic push;
  logic pop;

  assign in_ready = (q.cnt != CW'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data = q.mem[q.rp];
  assign push = in_valid & in_ready;
  assign pop = out_ready & out_valid;

  // ---------------------------------------------------------------
  // Pointer and storage update
  // ---------------------------------------------------------------
  // A refused push leaves the array alone, so overflow never corrupts.
  always_comb begin
    d = q;
    if (!rstn || clear) begin
      d.wp = '0;
      d.rp = '0;
      d.cnt = '0;
    end else begin
      if (push) begin
        d.mem[q.wp] = in_data;
        d.wp = q.wp + AW'(1);
      end
      if (pop) begin
        d.rp = q.rp + AW'(1);
      end
      d.cnt = q.cnt + CW'(push) - CW'(pop);
    end
  end

  // State register.
  always_ff @(posedge sys_clk) begin
    q <= d;
  end

endmodule

// ### core/dual_clock_fifo_read_threshold.sv
`timescale 1ns/10ps

`include "dcfifo_consts.svh"

module dual_clock_fifo_read_threshold #(
  parameter int WIDTH = `FIFO_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH,
  parameter bit SEPARATE_THRESH = 1'b0,
  parameter bit ECC_EN = 1'b1,
  parameter bit BUILTIN = 1'b1,
  localparam int LW = $clog2(DEPTH + 1)
) (
  input wire logic sys_clk, // System clock, 100 MHz.
  input wire logic rstn, // Write side reset, synchronous, active low.
  input wire logic wr_en, // Write request.
  input wire logic [WIDTH-1:0] din, // Write data.
  input wire logic inject_sbit, // Single bit error injection.
  input wire logic inject_dbit, // Double bit error injection.
  input wire logic [LW-1:0] thresh, // Shared full threshold.
  input wire logic [LW-1:0] thresh_assert, // Upper full level.
  input wire logic [LW-1:0] thresh_negate, // Lower full level.
  output logic full, // No room for a write.
  output logic prog_full, // Programmable full flag.
  output logic wr_rst_busy, // Write side held in reset.
  input wire logic rd_clk, // Read clock pin, sampled.
  input wire logic rd_rst, // Read reset, active high.
  input wire logic rd_en, // Read request.
  output logic [WIDTH-1:0] dout, // Read data.
  output logic empty // No stored word.
);

  if (WIDTH < 2 || DEPTH < 2) begin : g_bad_geom
    $error("width and depth must both be at least 2");
  end

  typedef struct packed {
    logic [LW-1:0] level;
    logic full;
    logic empty;
    logic pfull;
    logic [LW-1:0] thr_hi;
    logic [LW-1:0] thr_lo;
    logic busy;
    logic [WIDTH-1:0] dout;
    dcfifo_pkg::pin_sync_type rclk;
    dcfifo_pkg::pin_sync_type ren;
    dcfifo_pkg::pin_sync_type rrst;
  } state_type;

  state_type q;
  state_type d;
  logic rd_edge;
  logic flush;
  logic pop;
  logic push;
  logic in_ready;
  logic out_valid;
  logic [WIDTH-1:0] out_data;
  logic [WIDTH-1:0] err_mask;
  logic [WIDTH-1:0] store_word;
  dcfifo_pkg::pin_sync_type rclk_nx;
  dcfifo_pkg::pin_sync_type ren_nx;
  dcfifo_pkg::pin_sync_type rrst_nx;

  // ---------------------------------------------------------------
  // Error injection
  // ---------------------------------------------------------------
  // The flip goes into the stored copy only; din itself is untouched.
  always_comb begin
    err_mask = '0;
    if (ECC_EN && inject_dbit) begin
      err_mask[`SBIT_POS] = 1'b1;
      err_mask[`DBIT_POS] = 1'b1;
    end else if (ECC_EN && inject_sbit) begin
      err_mask[`SBIT_POS] = 1'b1;
    end
  end

  assign store_word = din ^ err_mask;

  // ---------------------------------------------------------------
  // Read clock events
  // ---------------------------------------------------------------
  // The read pins share one synchroniser depth, so rd_en and rd_rst line
  // up with the read clock edge they were set up against. The next sampled
  // values come straight from the register, which keeps the event logic
  // out of a loop through the next state copy.
  assign rclk_nx = dcfifo_pkg::sync_step(q.rclk, rd_clk);
  assign ren_nx = dcfifo_pkg::sync_step(q.ren, rd_en);
  assign rrst_nx = dcfifo_pkg::sync_step(q.rrst, rd_rst);
  assign rd_edge = rclk_nx.flt & ~q.rclk.flt;
  assign flush = rd_edge & rrst_nx.flt;
  assign pop = rd_edge & ~rrst_nx.flt & ren_nx.flt & out_valid;
  assign push = wr_en & ~q.full & in_ready & ~flush;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.rclk = rclk_nx;
    d.ren = ren_nx;
    d.rrst = rrst_nx;
    if (!rstn) begin
      // Thresholds are only taken here, so later changes do nothing.
      d.level = '0;
      d.full = 1'b0;
      d.empty = `EMPTY_RST;
      d.pfull = `PFULL_RST;
      d.dout = {WIDTH{`DOUT_RST}};
      d.busy = BUILTIN;
      d.rclk.flt = 1'b0;
      if (SEPARATE_THRESH) begin
        d.thr_hi = thresh_assert;
        d.thr_lo = thresh_negate;
      end else begin
        d.thr_hi = thresh;
        d.thr_lo = thresh;
      end
    end else begin
      d.busy = 1'b0;
      if (flush) begin
        d.level = '0;
        d.dout = {WIDTH{`DOUT_RST}};
      end else begin
        d.level = q.level + LW'(push) - LW'(pop);
        if (pop) begin
          d.dout = out_data;
        end
      end
      d.full = (d.level == LW'(DEPTH));
      d.empty = (d.level == '0);
      // Hysteresis: between the two levels the flag keeps its value.
      if (d.level >= q.thr_hi) begin
        d.pfull = 1'b1;
      end else if (d.level < q.thr_lo) begin
        d.pfull = 1'b0;
      end
    end
  end

  // State register.
  always_ff @(posedge sys_clk) begin
    q <= d;
  end

  assign full = q.full;
  assign prog_full = q.pfull;
  assign wr_rst_busy = q.busy;
  assign dout = q.dout;
  assign empty = q.empty;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  word_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_store (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clear(flush),
    .in_valid(push),
    .in_ready(in_ready),
    .in_data(store_word),
    .out_valid(out_valid),
    .out_ready(pop),
    .out_data(out_data)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking

  full_blocks_write_a: assert property (
    disable iff (!rstn) q.full && wr_en && !pop && !flush
      |=> q.level == $past(q.level))
    else $error("write accepted while full");

  empty_blocks_read_a: assert property (
    disable iff (!rstn) q.empty |-> !pop)
    else $error("read taken while empty");

  empty_level_a: assert property (
    disable iff (!rstn) $past(rstn) |-> empty == !out_valid)
    else $error("empty flag disagrees with count");

  pop_dout_a: assert property (
    disable iff (!rstn) pop |=> dout == $past(out_data))
    else $error("popped word not on dout");

  dout_on_edge_a: assert property (
    disable iff (!rstn) $past(rstn) && !$stable(dout) |-> $past(rd_edge))
    else $error("dout moved without a read clock edge");

  read_reset_a: assert property (
    disable iff (!rstn) flush |=> dout == '0 && empty && !full)
    else $error("read reset did not clear read state");

  pfull_rise_a: assert property (
    disable iff (!rstn) $rose(prog_full) |-> q.level >= q.thr_hi)
    else $error("prog_full rose below upper level");

  pfull_fall_a: assert property (
    disable iff (!rstn) $past(rstn) && $fell(prog_full)
      |-> q.level < q.thr_lo)
    else $error("prog_full fell at or above lower level");

  busy_reset_a: assert property (
    !rstn |=> wr_rst_busy == BUILTIN)
    else $error("busy not set during reset");

  busy_release_a: assert property (
    rstn |=> !wr_rst_busy)
    else $error("busy stayed high after reset");

  reset_clears_a: assert property (
    !rstn |=> q.level == '0 && empty && !prog_full)
    else $error("write reset left state behind");

  thresh_hold_a: assert property (
    disable iff (!rstn) $past(rstn)
      |-> $stable(q.thr_hi) && $stable(q.thr_lo))
    else $error("threshold moved outside reset");

  sbit_inject_a: assert property (
    disable iff (!rstn) ECC_EN && inject_sbit && !inject_dbit
      |-> $countones(store_word ^ din) == 1)
    else $error("single injection did not flip one bit");

  dbit_inject_a: assert property (
    disable iff (!rstn) ECC_EN && inject_dbit
      |-> $countones(store_word ^ din) == 2)
    else $error("double injection did not flip two bits");

endmodule

// ### dv/read_side_model.sv
`timescale 1ns/10ps

// Consumer on the read side. The read clock stands low between requests,
// so every rise it makes is one deliberate read or read reset.
module read_side_model (
  output logic rd_clk, // Read clock pin, 125 ns period while active.
  output logic rd_en, // Read request.
  output logic rd_rst // Read reset, active high.
);
  // Idle levels at time zero.
  initial begin
    rd_clk = 1'b0;
    rd_en = 1'b0;
    rd_rst = 1'b0;
  end

  // One read clock period; the qualifiers stand half a period before the rise
  // and a whole period after it, so the sampling synchroniser sees them settled.
  task automatic tick(input logic en, input logic rst);
    #1;
    rd_en = en;
    rd_rst = rst;
    #62.5 rd_clk = 1'b1;
    #62.5 rd_clk = 1'b0;
    #62.5 rd_en = 1'b0;
    rd_rst = 1'b0;
  endtask
endmodule

// ### dv/dual_clock_fifo_read_threshold_tb.sv
`timescale 1ns/10ps

module dual_clock_fifo_read_threshold_tb;
  typedef struct packed {
    int rd;
    logic [7:0] d;
    int em;
    int fu;
    int pf;
  } row_type;

  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic wr_en = 1'b0;
  logic [7:0] din = 8'h00;
  logic inject_sbit = 1'b0;
  logic inject_dbit = 1'b0;
  logic [3:0] thresh = 4'h6;
  logic [3:0] thresh_assert = 4'h6;
  logic [3:0] thresh_negate = 4'h3;
  logic full, prog_full, wr_rst_busy, rd_clk, rd_rst, rd_en, empty;
  logic [7:0] dout;
  // Second build: shared threshold, no ECC, no busy output.
  logic full_sh, pfull_sh, busy_sh, empty_sh;
  logic [7:0] dout_sh;
  int lvl = 0;
  int failures = 0;
  int n_checks = 0;
  // Eight writes then eight reads; upper level 6, lower level 3.
  row_type rows [16] = '{
    '{0, 8'h11, 0, 0, 0}, '{0, 8'h22, 0, 0, 0}, '{0, 8'h33, 0, 0, 0},
    '{0, 8'h44, 0, 0, 0}, '{0, 8'h55, 0, 0, 0}, '{0, 8'h66, 0, 0, 1},
    '{0, 8'h77, 0, 0, 1}, '{0, 8'h88, 0, 1, 1}, '{1, 8'h11, 0, 0, 1},
    '{1, 8'h22, 0, 0, 1}, '{1, 8'h33, 0, 0, 1}, '{1, 8'h44, 0, 0, 1},
    '{1, 8'h55, 0, 0, 1}, '{1, 8'h66, 0, 0, 0}, '{1, 8'h77, 0, 0, 0},
    '{1, 8'h88, 1, 0, 0}};

  // System clock, 10 ns period.
  always #5 sys_clk = ~sys_clk;

  dual_clock_fifo_read_threshold #(.SEPARATE_THRESH(1'b1)) dut (
    .sys_clk(sys_clk), .rstn(rstn), .wr_en(wr_en), .din(din),
    .inject_sbit(inject_sbit), .inject_dbit(inject_dbit), .thresh(thresh),
    .thresh_assert(thresh_assert), .thresh_negate(thresh_negate),
    .full(full), .prog_full(prog_full), .wr_rst_busy(wr_rst_busy),
    .rd_clk(rd_clk), .rd_rst(rd_rst), .rd_en(rd_en), .dout(dout),
    .empty(empty));

  // Same stimulus into the other build options of the block.
  dual_clock_fifo_read_threshold #(.SEPARATE_THRESH(1'b0), .ECC_EN(1'b0),
    .BUILTIN(1'b0)) dut_shared (
    .sys_clk(sys_clk), .rstn(rstn), .wr_en(wr_en), .din(din),
    .inject_sbit(inject_sbit), .inject_dbit(inject_dbit), .thresh(thresh),
    .thresh_assert(thresh_assert), .thresh_negate(thresh_negate),
    .full(full_sh), .prog_full(pfull_sh), .wr_rst_busy(busy_sh),
    .rd_clk(rd_clk), .rd_rst(rd_rst), .rd_en(rd_en), .dout(dout_sh),
    .empty(empty_sh));

  read_side_model rd (.rd_clk(rd_clk), .rd_en(rd_en), .rd_rst(rd_rst));

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One write cycle; the flags are registered on the taking edge itself.
  task automatic push(input logic [7:0] d, input logic s, input logic db);
    @(posedge sys_clk);
    wr_en <= 1'b1;
    din <= d;
    inject_sbit <= s;
    inject_dbit <= db;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    inject_sbit <= 1'b0;
    inject_dbit <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  // One read clock rise, then time for the synchroniser and dout to land.
  task automatic pop(input logic rst);
    @(posedge sys_clk);
    rd.tick(!rst, rst);
    repeat (3) @(posedge sys_clk);
  endtask

  // Thresholds are set together with reset, where the block captures them; changes after reset do not count.
  task automatic do_reset(input logic [3:0] hi, input logic [3:0] lo);
    @(posedge sys_clk);
    rstn <= 1'b0;
    thresh_assert <= hi;
    thresh_negate <= lo;
    repeat (6) @(posedge sys_clk);
    check("busy", 8'(wr_rst_busy), 8'h01);
    check("busy shared", 8'(busy_sh), 8'h00);
    check("empty", 8'(empty), 8'h01);
    check("full", 8'(full), 8'h00);
    check("pfull", 8'(prog_full), 8'h00);
    check("dout", dout, 8'h00);
    rstn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check("busy", 8'(wr_rst_busy), 8'h00);
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    do_reset(4'h6, 4'h3);
    foreach (rows[i]) begin
      if (rows[i].rd) begin
        pop(1'b0);
        lvl--;
        check("dout", dout, rows[i].d);
      end else begin
        push(rows[i].d, 1'b0, 1'b0);
        lvl++;
      end
      // One shared level of 6 leaves no band between rise and fall.
      check("pfull shared", 8'(pfull_sh), 8'(lvl >= 6));
      check("empty", 8'(empty), 8'(rows[i].em));
      check("full", 8'(full), 8'(rows[i].fu));
      check("pfull", 8'(prog_full), 8'(rows[i].pf));
    end
    $display("test table done");
    // A read while empty must leave dout and the flag alone.
    pop(1'b0);
    check("dout", dout, 8'h88);
    check("empty", 8'(empty), 8'h01);
    check("empty shared", 8'(empty_sh), 8'h01);
    $display("test empty read done");
    // Fill, offer one word too many, and drain in order.
    for (int i = 1; i <= 8; i++) push(8'(i), 1'b0, 1'b0);
    push(8'hEE, 1'b0, 1'b0);
    check("full", 8'(full), 8'h01);
    check("full shared", 8'(full_sh), 8'h01);
    for (int i = 1; i <= 8; i++) begin
      pop(1'b0);
      check("dout", dout, 8'(i));
    end
    check("empty", 8'(empty), 8'h01);
    $display("test overflow done");
    // Error injection; double injection wins over single.
    push(8'h40, 1'b1, 1'b0);
    push(8'h40, 1'b0, 1'b1);
    push(8'h40, 1'b1, 1'b1);
    pop(1'b0);
    check("dout", dout, 8'h41);
    check("dout shared", dout_sh, 8'h40);
    pop(1'b0);
    check("dout", dout, 8'h43);
    check("dout shared", dout_sh, 8'h40);
    pop(1'b0);
    check("dout", dout, 8'h43);
    check("dout shared", dout_sh, 8'h40);
    $display("test inject done");
    // Read reset with words stored.
    push(8'h12, 1'b0, 1'b0);
    push(8'h34, 1'b0, 1'b0);
    pop(1'b1);
    check("empty", 8'(empty), 8'h01);
    check("dout", dout, 8'h00);
    push(8'h5A, 1'b0, 1'b0);
    pop(1'b0);
    check("dout", dout, 8'h5A);
    $display("test read reset done");
    // New levels captured in reset; later input changes must not count.
    do_reset(4'h2, 4'h1);
    @(posedge sys_clk);
    thresh_assert <= 4'h8;
    thresh_negate <= 4'h8;
    push(8'h01, 1'b0, 1'b0);
    push(8'h02, 1'b0, 1'b0);
    check("pfull", 8'(prog_full), 8'h01);
    pop(1'b0);
    check("pfull", 8'(prog_full), 8'h01);
    pop(1'b0);
    check("pfull", 8'(prog_full), 8'h00);
    $display("test threshold capture done");
    complete_run();
  end

  // The sequence needs about 7 us; a hang is cut off well beyond that.
  initial begin
    #100_000;
    failures++;
    complete_run();
  end
endmodule
